// ### apsm_aperture_size_mask.v
`timescale 1ns/1ps
`include "apsm_consts.vh"
// How it works
// - Size bits 5:0 each gate the same-order base bit among 27:22.
// - A zero size bit makes its base bit read zero and ignore writes.
// - A one size bit makes its base bit ordinary read/write storage.
// - Reset clears the size register, giving the 256 MB aperture.
// - Ones filled from the top shrink the aperture from 256 MB to 4 MB.
module apsm_aperture_size_mask (
  input  wire        clock,
  input  wire        resetn,
  input  wire [7:0]  cfg_addr,
  input  wire        cfg_wr,
  input  wire [7:0]  cfg_wdata,
  output reg  [7:0]  cfg_rdata,
  input  wire        base_wr,
  input  wire [5:0]  base_wdata,
  output wire [5:0]  base_rdata,
  output wire [5:0]  base_mask,
  output reg  [8:0]  aperture_mb
);

  // Size codes name the seven legal patterns; the last code marks anything else.
  localparam [2:0] CODE_256  = 3'h0;
  localparam [2:0] CODE_128  = 3'h1;
  localparam [2:0] CODE_64   = 3'h2;
  localparam [2:0] CODE_32   = 3'h3;
  localparam [2:0] CODE_16   = 3'h4;
  localparam [2:0] CODE_8    = 3'h5;
  localparam [2:0] CODE_4    = 3'h6;
  localparam [2:0] CODE_NONE = 3'h7;

  reg  [5:0] aperture_size_field;
  reg  [5:0] next_aperture_size_field;

  reg  [7:0] next_cfg_rdata;

  reg  [2:0] size_code;
  reg  [2:0] next_size_code;
  reg  [8:0] next_aperture_mb;

  wire       size_sel;
  wire       size_write;
  wire [5:0] size_write_bits;
  wire [7:0] size_read_word;
  wire [4:0] therm_step;
  wire       size_is_therm;

  genvar s;
  genvar r;

  assign size_sel = (cfg_addr == `APSM_SIZE_OFFSET);

  assign size_write = cfg_wr & size_sel;

  assign size_write_bits = cfg_wdata[`APSM_SIZE_MSB:`APSM_SIZE_LSB];

  // The size field drives the base mask directly, so a new size acts on the next edge.
  assign base_mask = aperture_size_field;

  // Bits 7:6 have no flop at all, so no write can ever leave a stray one there.
  generate
    for (r = 0; r < 8; r = r + 1) begin : g_read
      if (r > `APSM_SIZE_MSB) begin : g_rsvd
        assign size_read_word[r] = 1'b0;
      end else begin : g_field
        assign size_read_word[r] = aperture_size_field[r];
      end
    end
  endgenerate

  // A one under a zero breaks the pattern filled from the top down.
  generate
    for (s = 0; s < 5; s = s + 1) begin : g_therm
      assign therm_step[s] = ~next_aperture_size_field[s] | next_aperture_size_field[s + 1];
    end
  endgenerate

  assign size_is_therm = &therm_step;

  always @* begin
    next_aperture_size_field = aperture_size_field;
    if (size_write) begin
      next_aperture_size_field = size_write_bits;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aperture_size_field <= `APSM_FIELD_RESET;
    end else begin
      aperture_size_field <= next_aperture_size_field;
    end
  end

  // The read path is registered: one cycle of latency buys an output free of
  // address decode glitches.
  always @* begin
    next_cfg_rdata = 8'h00;
    if (size_sel) begin
      next_cfg_rdata = size_read_word;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= `APSM_SIZE_RESET;
    end else begin
      cfg_rdata <= next_cfg_rdata;
    end
  end

  // The code follows the field on the same edge, so aperture_mb lands one
  // edge after the field changes.
  always @* begin
    next_size_code = CODE_NONE;
    if (size_is_therm) begin
      case (next_aperture_size_field)
        `APSM_PAT_256: begin
          next_size_code = CODE_256;
        end

        `APSM_PAT_128: begin
          next_size_code = CODE_128;
        end

        `APSM_PAT_64: begin
          next_size_code = CODE_64;
        end

        `APSM_PAT_32: begin
          next_size_code = CODE_32;
        end

        `APSM_PAT_16: begin
          next_size_code = CODE_16;
        end

        `APSM_PAT_8: begin
          next_size_code = CODE_8;
        end

        `APSM_PAT_4: begin
          next_size_code = CODE_4;
        end

        default: begin
          next_size_code = CODE_NONE;
        end
      endcase
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      size_code <= CODE_256;
    end else begin
      size_code <= next_size_code;
    end
  end

  // Patterns not filled from the top report zero, since they give software no
  // power-of-two range to size against.
  always @* begin
    next_aperture_mb = `APSM_MB_NONE;
    case (size_code)
      CODE_256: begin
        next_aperture_mb = `APSM_MB_256;
      end

      CODE_128: begin
        next_aperture_mb = `APSM_MB_128;
      end

      CODE_64: begin
        next_aperture_mb = `APSM_MB_64;
      end

      CODE_32: begin
        next_aperture_mb = `APSM_MB_32;
      end

      CODE_16: begin
        next_aperture_mb = `APSM_MB_16;
      end

      CODE_8: begin
        next_aperture_mb = `APSM_MB_8;
      end

      CODE_4: begin
        next_aperture_mb = `APSM_MB_4;
      end

      default: begin
        next_aperture_mb = `APSM_MB_NONE;
      end
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aperture_mb <= `APSM_MB_256;
    end else begin
      aperture_mb <= next_aperture_mb;
    end
  end

  // Clearing a size bit also clears its stored base bit, so re-enabling it reads zero.
  apsm_base_bits u_base (
    .clock      (clock),
    .resetn     (resetn),
    .size_mask  (aperture_size_field),
    .base_wr    (base_wr),
    .base_wdata (base_wdata),
    .base_rdata (base_rdata)
  );
endmodule // apsm_aperture_size_mask

// ### apsm_aperture_size_mask_monitor.sv
`timescale 1ns/1ps
module apsm_monitor (input clock, resetn, cfg_wr, base_wr, input [7:0] cfg_addr,
  cfg_wdata, cfg_rdata, input [5:0] base_wdata, base_rdata, base_mask, input [8:0] aperture_mb);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_mask_zero: assert property (!(base_rdata & ~base_mask)) else $error("mask");
  chk_base_store: assert property (base_wr && !cfg_wr |=>
    base_rdata == $past(base_wdata & base_mask)) else $error("store");
  chk_size_load: assert property (cfg_wr && cfg_addr == 8'hB4 |=>
    base_mask == $past(cfg_wdata[5:0])) else $error("load");
  chk_read_back: assert property (cfg_addr == 8'hB4 && !cfg_wr |=>
    cfg_rdata == {2'h0, $past(base_mask)}) else $error("read");
  chk_size_min: assert property (base_mask == 6'h3F |=> aperture_mb == 9'h004)
    else $error("min");
  chk_rsvd_read: assert property (cfg_rdata[7:6] == 2'h0) else $error("rsvd");
  chk_other_addr: assert property (cfg_addr != 8'hB4 |=> cfg_rdata == 8'h00)
    else $error("addr");
  chk_size_hold: assert property (!(cfg_wr && cfg_addr == 8'hB4) |=> $stable(base_mask))
    else $error("hold");
  chk_size_max: assert property (base_mask == 6'h00 |=> aperture_mb == 9'h100)
    else $error("max");
  cover property (base_wr && base_mask == 6'h3F);
  cover property (aperture_mb == 9'h000);
  cover property (aperture_mb == 9'h008);
  cover property (cfg_wr && cfg_wdata[7:6] != 2'h0);
endmodule // apsm_monitor
bind apsm_aperture_size_mask apsm_monitor mon (.*);

// ### apsm_aperture_size_mask_tb_top.sv
`timescale 1ns/1ps
module apsm_aperture_size_mask_tb_top;
  logic clock=0, resetn=0, cfg_wr=0, base_wr=0;
  logic [7:0] cfg_addr=0, cfg_wdata=0, cfg_rdata;
  logic [5:0] base_wdata=0, base_rdata, base_mask, m, b;
  logic [8:0] aperture_mb; logic [28:0] q[$];
  int miscompares=0, samples_checked=0, k;
  apsm_aperture_size_mask dut (.clock(clock), .resetn(resetn), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .base_wr(base_wr),
    .base_wdata(base_wdata), .base_rdata(base_rdata), .base_mask(base_mask),
    .aperture_mb(aperture_mb));
  initial forever #5 clock = ~clock;
  task cmp(input logic [28:0] e, g); samples_checked++;
    if (e !== g) begin miscompares++; $display("[ERR] %0t got %h", $time, g); end
  endtask
  task report_and_stop; $display("%0d %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish; endtask
  always @(negedge clock) if (q.size())
    cmp(q.pop_front(), {cfg_rdata, base_mask, base_rdata, aperture_mb});
  initial begin #9000 miscompares++; report_and_stop; end
  initial begin void'($urandom(47)); repeat (4) @(posedge clock);
    resetn <= 1; q.push_back(29'h100);
    repeat (20) begin k = $urandom % 7; m = ~(6'h3F >> k);
      @(posedge clock); cfg_addr <= 8'hB4; cfg_wr <= 1; cfg_wdata <= {2'h3, m};
      @(posedge clock); cfg_wr <= 0; base_wr <= 1; base_wdata <= 6'($urandom);
      @(posedge clock); base_wr <= 0; $display("test"); b = base_wdata & m;
      q.push_back({2'h0, m, m, b, 9'h100 >> k}); end
    @(posedge clock); cfg_addr <= 8'hB5; cfg_wr <= 1; cfg_wdata <= 8'h00;
    @(posedge clock); cfg_wr <= 0;
    @(posedge clock); $display("test"); q.push_back({8'h00, m, b, 9'h100 >> k});
    cfg_addr <= 8'hB4; cfg_wr <= 1; cfg_wdata <= 8'h15;
    @(posedge clock); cfg_wr <= 0;
    @(posedge clock); $display("test"); q.push_back({8'h15, 6'h15, b & 6'h15, 9'h000});
    @(posedge clock); report_and_stop; end
endmodule // apsm_aperture_size_mask_tb_top

// ### apsm_base_bits.v
`timescale 1ns/1ps
`include "apsm_consts.vh"
module apsm_base_bits (
  input  wire       clock,
  input  wire       resetn,
  input  wire [5:0] size_mask,
  input  wire       base_wr,
  input  wire [5:0] base_wdata,
  output wire [5:0] base_rdata
);
  localparam [5:0] BASE_RESET_WORD = `APSM_BASE_RESET;

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_bit
      reg store_q;
      // A masked bit accepts no write, and its stored value is dropped.
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          store_q <= BASE_RESET_WORD[i];
        end else if (!size_mask[i]) begin
          store_q <= 1'b0;
        end else if (base_wr) begin
          store_q <= base_wdata[i];
        end
      end
      assign base_rdata[i] = store_q & size_mask[i];
    end
  endgenerate
endmodule // apsm_base_bits

// ### apsm_consts.vh
`ifndef APSM_CONSTS_VH
`define APSM_CONSTS_VH
`define APSM_SIZE_OFFSET   8'hB4
`define APSM_SIZE_RESET    8'h00
`define APSM_SIZE_MSB      5
`define APSM_SIZE_LSB      0
`define APSM_BASE_MSB      27
`define APSM_BASE_LSB      22
`define APSM_BASE_RESET    6'h00
`define APSM_FIELD_RESET   6'h00
`define APSM_PAT_256       6'h00
`define APSM_PAT_128       6'h20
`define APSM_PAT_64        6'h30
`define APSM_PAT_32        6'h38
`define APSM_PAT_16        6'h3C
`define APSM_PAT_8         6'h3E
`define APSM_PAT_4         6'h3F
`define APSM_MB_NONE       9'h000
`define APSM_MB_256        9'h100
`define APSM_MB_128        9'h080
`define APSM_MB_64         9'h040
`define APSM_MB_32         9'h020
`define APSM_MB_16         9'h010
`define APSM_MB_8          9'h008
`define APSM_MB_4          9'h004
`endif
